// >>> rtl/mcs_ctrl.sv
`timescale 1ns/100ps
module mcs_ctrl
    import mcs_pkg::*;
#(
    parameter int StuckCycles = STUCK_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  mcs_supply_s      supplyOk,
    input  wire logic        refClockIn,
    input  wire logic        intOscTick,
    input  wire logic [1:0]  addrSelectPinHi,
    input  wire logic [1:0]  addrSelectPinLo,
    input  wire logic        sclIn,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    output mcs_power_s       powerCtl,
    output logic             sampClk,
    output logic             extRefActive,
    output logic             alertOut
);
    mcs_bus_e    st_q, st_d;
    logic [2:0]  cnt_q, cnt_d;
    logic [7:0]  sh_q, sh_d;
    logic [7:0]  ptr_q, ptr_d;
    logic        rw_q, rw_d;
    logic        oe_q, oe_d;
    logic        done_q, done_d;
    logic        ack_q, ack_d;
    logic        sclPrev_q, sdaPrev_q;
    logic        sclRise, sclFall, startCond, stopCond, wrEn;
    logic [7:0]  rdData;
    logic [7:0]  adcCtrl_q, adcCtrl_d, sysCtrl_q, sysCtrl_d;
    logic [7:0]  alertEn_q, alertEn_d, fault_q, fault_d, clkDiv_q, clkDiv_d;
    logic [3:0]  addrLatch_q, addrLatch_d;
    logic [22:0] stuckCnt_q, stuckCnt_d;
    logic        stuck_q, stuck_d, wake;
    logic        refPrev_q, extRef_q, extRef_d;
    logic [7:0]  refIdle_q, refIdle_d;
    logic        refTick, adcAlive, busAlive, shutdown;
    logic [7:0]  status_reg_two;

    // undervoltage lockout: adc alive while either supply is up
    assign adcAlive = supplyOk.vddUvloOk | supplyOk.railUvloOk;
    // bus logic held in reset only when both drop under bus-reset level
    assign busAlive = supplyOk.vddBusOk | supplyOk.railBusOk;
    assign shutdown = sysCtrl_q[SHDN_BIT];

    // line edges, inputs already synchronous
    assign sclRise = sclIn & ~sclPrev_q;
    assign sclFall = ~sclIn & sclPrev_q;
    assign startCond = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
    assign stopCond = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;

    function automatic logic [7:0] regRead(input logic [7:0] a, input logic [7:0] c,
                                           input logic [7:0] s, input logic [7:0] e,
                                           input logic [7:0] st, input logic [7:0] f,
                                           input logic [7:0] d);
        logic [7:0] r;
        r = READ_ZERO;
        unique case (a)
            ADDR_ADC_CTRL: r = c;
            ADDR_SYS_CTRL: r = s;
            ADDR_ALERT_EN2: r = e;
            ADDR_STATUS_REG_TWO: r = st;
            ADDR_FAULT_LATCH_REG_TWO: r = f;
            ADDR_CLK_DIV: r = d;
            default: r = READ_ZERO;
        endcase
        return r;
    endfunction

    assign status_reg_two = 8'(stuck_q) << STUCK_FLAG_BIT;
    // reads stay available in shutdown, nothing gates the decode
    assign rdData = regRead(ptr_q, adcCtrl_q, sysCtrl_q, alertEn_q, status_reg_two, fault_q,
                            clkDiv_q);

    // serial slave: shifts on scl rise, drives on scl fall
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        oe_d = oe_q;
        done_d = done_q;
        ack_d = ack_q;
        wrEn = 1'b0;
        if (startCond) begin
            st_d = ST_ADDR;
            cnt_d = 3'h0;
            done_d = 1'b0;
            oe_d = 1'b0;
        end else if (stopCond) begin
            st_d = ST_IDLE;
            oe_d = 1'b0;
        end else if (sclRise) begin
            if (st_q == ST_ADDR || st_q == ST_CMD || st_q == ST_WDAT) begin
                sh_d = {sh_q[6:0], sdaIn};
                cnt_d = cnt_q + 3'h1;
                done_d = (cnt_q == 3'h7);
            end else if (st_q == ST_RACK) begin
                ack_d = ~sdaIn;
                ptr_d = ptr_q + 8'h01;
                if (sdaIn) begin
                    st_d = ST_IDLE;
                end
            end
        end else if (sclFall) begin
            unique case (st_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        // match against the latched pin address, frozen while shut down
                        if (sh_q[7:1] == {BUS_ADDR_HI, addrLatch_q}) begin
                            oe_d = 1'b1;
                            rw_d = sh_q[0];
                            st_d = ST_AACK;
                        end else begin
                            st_d = ST_IDLE;
                        end
                    end
                end
                ST_CMD: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        ptr_d = sh_q;
                        oe_d = 1'b1;
                        st_d = ST_CACK;
                    end
                end
                ST_WDAT: begin
                    if (done_q) begin
                        done_d = 1'b0;
                        wrEn = 1'b1;
                        oe_d = 1'b1;
                        st_d = ST_WACK;
                    end
                end
                ST_CACK: begin
                    oe_d = 1'b0;
                    st_d = ST_WDAT;
                end
                ST_WACK: begin
                    oe_d = 1'b0;
                    ptr_d = ptr_q + 8'h01;
                    st_d = ST_WDAT;
                end
                ST_RDAT: begin
                    if (cnt_q == 3'h0) begin
                        oe_d = 1'b0;
                        st_d = ST_RACK;
                    end else begin
                        oe_d = ~sh_q[7];
                        sh_d = {sh_q[6:0], 1'b0};
                        cnt_d = cnt_q + 3'h1;
                    end
                end
                ST_AACK, ST_RACK: begin
                    oe_d = 1'b0;
                    if (st_q == ST_AACK && !rw_q) begin
                        st_d = ST_CMD;
                    end else if (st_q == ST_AACK || ack_q) begin
                        sh_d = {rdData[6:0], 1'b0};
                        oe_d = ~rdData[7];
                        cnt_d = 3'h1;
                        st_d = ST_RDAT;
                    end
                end
            endcase
        end
    end

    // register file; bus-reset level clears, shutdown never does
    always_comb begin
        adcCtrl_d = adcCtrl_q;
        sysCtrl_d = sysCtrl_q;
        alertEn_d = alertEn_q;
        fault_d = fault_q;
        clkDiv_d = clkDiv_q;
        // address pins ignored while shut down
        addrLatch_d = shutdown ? addrLatch_q : {addrSelectPinHi, addrSelectPinLo};
        if (wrEn) begin
            unique case (ptr_q)
                ADDR_ADC_CTRL: adcCtrl_d = sh_q;
                ADDR_SYS_CTRL: sysCtrl_d = sh_q;
                ADDR_ALERT_EN2: alertEn_d = sh_q;
                ADDR_FAULT_LATCH_REG_TWO: fault_d = fault_q & sh_q;
                ADDR_CLK_DIV: clkDiv_d = sh_q;
                default: fault_d = fault_q;
            endcase
        end
        // wake beats a same-cycle write of the shutdown bit or fault clear
        if (wake) begin
            sysCtrl_d[SHDN_BIT] = 1'b0;
            fault_d[STUCK_FLAG_BIT] = 1'b1;
        end
    end

    // stuck-bus watch and reference detection
    always_comb begin
        stuckCnt_d = stuckCnt_q;
        stuck_d = stuck_q;
        extRef_d = extRef_q;
        refIdle_d = refIdle_q;
        if (!sclIn && !sdaIn) begin
            if (stuckCnt_q != 23'(StuckCycles)) begin
                stuckCnt_d = stuckCnt_q + 23'h000001;
            end else begin
                stuck_d = 1'b1;
            end
        end else begin
            stuckCnt_d = 23'h000000;
            stuck_d = 1'b0;
        end
        // a grounded reference input shows no edges, fall back to oscillator
        if (refClockIn && !refPrev_q) begin
            refIdle_d = 8'h00;
            extRef_d = 1'b1;
        end else if (refIdle_q == 8'(REF_LOST_CYCLES)) begin
            extRef_d = 1'b0;
        end else begin
            refIdle_d = refIdle_q + 8'h01;
        end
    end
    assign wake = stuck_d & ~stuck_q & sysCtrl_q[WAKE_EN_BIT];

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            cnt_q <= 3'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            oe_q <= 1'b0;
            done_q <= 1'b0;
            ack_q <= 1'b0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            adcCtrl_q <= RST_ADC_CTRL;
            sysCtrl_q <= RST_SYS_CTRL;
            alertEn_q <= RST_ALERT_EN2;
            fault_q <= 8'h00;
            clkDiv_q <= RST_CLK_DIV;
            addrLatch_q <= 4'h0;
            stuckCnt_q <= 23'h000000;
            stuck_q <= 1'b0;
            refPrev_q <= 1'b0;
            extRef_q <= 1'b0;
            refIdle_q <= 8'h00;
        end else if (!busAlive) begin
            st_q <= ST_IDLE;
            oe_q <= 1'b0;
            ptr_q <= 8'h00;
            adcCtrl_q <= RST_ADC_CTRL;
            sysCtrl_q <= RST_SYS_CTRL;
            alertEn_q <= RST_ALERT_EN2;
            fault_q <= 8'h00;
            clkDiv_q <= RST_CLK_DIV;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            oe_q <= oe_d;
            done_q <= done_d;
            ack_q <= ack_d;
            sclPrev_q <= sclIn;
            sdaPrev_q <= sdaIn;
            adcCtrl_q <= adcCtrl_d;
            sysCtrl_q <= sysCtrl_d;
            alertEn_q <= alertEn_d;
            fault_q <= fault_d;
            clkDiv_q <= clkDiv_d;
            addrLatch_q <= addrLatch_d;
            stuckCnt_q <= stuckCnt_d;
            stuck_q <= stuck_d;
            refPrev_q <= refClockIn;
            extRef_q <= extRef_d;
            refIdle_q <= refIdle_d;
        end
    end

    // on-chip oscillator uses a fixed divide, host divider ignored
    assign refTick = extRef_q ? (refClockIn & ~refPrev_q) : intOscTick;
    mcs_samp_div u_div (
        .sys_clk (sys_clk),
        .resetn  (resetn),
        .refTick (refTick),
        .divisor (extRef_q ? clkDiv_q : INT_OSC_DIV),
        .sampClk (sampClk)
    );

    // analog power follows shutdown; registers are not touched by it
    assign powerCtl.adcEn = adcAlive & ~shutdown;
    assign powerCtl.refEn = adcAlive & ~shutdown;
    assign powerCtl.regulatorEn = ~shutdown;
    assign powerCtl.auxRefToRail = adcCtrl_q[AUX_REF_BIT];
    assign alertOut = fault_q[STUCK_FLAG_BIT] & alertEn_q[ALERT_WAKE_BIT];
    assign sdaOut = 1'b0;
    assign sdaOe = oe_q;
    assign extRefActive = extRef_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_wake;
        $rose(stuck_q) && $past(sysCtrl_q[WAKE_EN_BIT]) && $past(busAlive);
    endsequence
    a_wake_exit: assert property (s_wake |-> !shutdown && fault_q[STUCK_FLAG_BIT])
        else $error("stuck bus wake did not end shutdown");
    a_alert_gate: assert property (wake && busAlive && !wrEn
                                   |=> alertOut == alertEn_q[ALERT_WAKE_BIT])
        else $error("alert not gated by enable");
    a_shdn_power: assert property (shutdown |-> !powerCtl.adcEn && !powerCtl.refEn
                                   && !powerCtl.regulatorEn)
        else $error("analog powered during shutdown");
    a_addr_hold: assert property (shutdown && $past(shutdown) |-> $stable(addrLatch_q))
        else $error("bus address moved during shutdown");
    a_fault_sticky: assert property (fault_q[STUCK_FLAG_BIT] && !wrEn && busAlive
                                     |=> fault_q[STUCK_FLAG_BIT])
        else $error("stuck fault dropped without a write");
    a_status_present: assert property (stuck_q |-> status_reg_two[STUCK_FLAG_BIT])
        else $error("present stuck status missing");
    a_uvlo_adc: assert property (!adcAlive |-> !powerCtl.adcEn)
        else $error("adc enabled below lockout");
    a_bus_reset: assert property (!busAlive |=> st_q == ST_IDLE && !sdaOe)
        else $error("bus logic alive below reset level");
    a_regs_kept: assert property (shutdown && !wrEn && busAlive |=> $stable(clkDiv_q)
                                  && $stable(adcCtrl_q))
        else $error("register changed in shutdown without a write");
    a_aux_ref: assert property (wrEn && busAlive && ptr_q == ADDR_ADC_CTRL
                                |=> powerCtl.auxRefToRail == $past(sh_q[AUX_REF_BIT]))
        else $error("aux reference select mismatch");
endmodule

// >>> rtl/mcs_pkg.sv
// Overview of operation
// - sampling clock equals reference clock divided by four times the divider value.
// - host may rewrite divider register 43h when an external reference is used.
// - reference input held low selects the trimmed on-chip oscillator.
// - aux reference bit makes aux input measured against the internal supply rail.
// - adc comes up when either supply passes its lockout level, bus logic when either passes its bus-reset level.
// - adc off only when both supplies low; bus reset only when both low.
// - shutdown bit powers down adc, internal reference and linear regulator.
// - in shutdown the bus stays alive, address pins ignored, latched address kept.
// - in shutdown all registers keep contents and stay readable and writable.
// - clearing shutdown restores analog power, registers left untouched.
// - with wake enable set, both bus lines low over 33ms end shutdown.
// - stuck-bus wake raises alert only when its alert enable bit is set.
// - stuck-bus wake shows as present status and latches into the fault register.
package mcs_pkg;
    localparam int SYS_CLK_MHZ = 125;
    localparam int STUCK_MS = 33;
    localparam int STUCK_CYCLES = STUCK_MS * SYS_CLK_MHZ * 1000;
    localparam int REF_LOST_NS = 2000;
    localparam int REF_LOST_CYCLES = (REF_LOST_NS * SYS_CLK_MHZ + 999) / 1000;
    // register addresses
    localparam logic [7:0] ADDR_ADC_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h01;
    localparam logic [7:0] ADDR_ALERT_EN2 = 8'h02;
    localparam logic [7:0] ADDR_STATUS_REG_TWO = 8'h03;
    localparam logic [7:0] ADDR_FAULT_LATCH_REG_TWO = 8'h04;
    localparam logic [7:0] ADDR_CLK_DIV = 8'h43;
    // reset values, fixed oscillator divide and unmapped read value
    localparam logic [7:0] RST_ADC_CTRL = 8'h00;
    localparam logic [7:0] RST_SYS_CTRL = 8'h00;
    localparam logic [7:0] RST_ALERT_EN2 = 8'h00;
    localparam logic [7:0] RST_CLK_DIV = 8'h04;
    localparam logic [7:0] INT_OSC_DIV = 8'h04;
    localparam logic [7:0] READ_ZERO = 8'h00;
    // field positions
    localparam int AUX_REF_BIT = 7;
    localparam int SHDN_BIT = 6;
    localparam int WAKE_EN_BIT = 4;
    localparam int ALERT_WAKE_BIT = 3;
    localparam int STUCK_FLAG_BIT = 1;
    // bus address: fixed upper bits, low four bits from address pins
    localparam logic [2:0] BUS_ADDR_HI = 3'h6;
    localparam logic [9:0] DIV_MULT = 10'h004;

    typedef struct packed {
        logic vddUvloOk;
        logic railUvloOk;
        logic vddBusOk;
        logic railBusOk;
    } mcs_supply_s;

    typedef struct packed {
        logic adcEn;
        logic refEn;
        logic regulatorEn;
        logic auxRefToRail;
    } mcs_power_s;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_AACK = 4'h3,
        ST_CMD  = 4'h2,
        ST_CACK = 4'h6,
        ST_WDAT = 4'h7,
        ST_WACK = 4'h5,
        ST_RDAT = 4'h4,
        ST_RACK = 4'hc
    } mcs_bus_e;
endpackage

// >>> rtl/mcs_samp_div.sv
`timescale 1ns/100ps
module mcs_samp_div
    import mcs_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       resetn,
    input  wire logic       refTick,
    input  wire logic [7:0] divisor,
    output logic            sampClk
);
    logic [9:0] cnt_q, cnt_d;
    logic [9:0] period_q, period_d;
    logic       clk_q, clk_d;
    logic       boundary;

    // one full period is 4 x divisor reference ticks; zero treated as one
    assign boundary = refTick && (cnt_q == 10'h000);
    always_comb begin
        cnt_d = cnt_q;
        period_d = period_q;
        clk_d = clk_q;
        if (boundary) begin
            // divisor only sampled here so no truncated pulse
            period_d = (divisor == 8'h00) ? DIV_MULT : {divisor, 2'b00};
            cnt_d = ((divisor == 8'h00) ? DIV_MULT : {divisor, 2'b00}) - 10'h001;
            clk_d = 1'b1;
        end else if (refTick) begin
            cnt_d = cnt_q - 10'h001;
            if (cnt_q == {1'b0, period_q[9:1]}) begin
                clk_d = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= 10'h000;
            period_q <= DIV_MULT;
            clk_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            period_q <= period_d;
            clk_q <= clk_d;
        end
    end

    assign sampClk = clk_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence s_midTick;
        refTick && !boundary ##0 (cnt_q == {1'b0, period_q[9:1]});
    endsequence
    a_period_latch: assert property ($changed(period_q) |-> $past(boundary))
        else $error("divider period changed off boundary");
    a_rise_boundary: assert property ($rose(clk_q) |-> $past(boundary))
        else $error("sampling clock rose away from period start");
    a_fall_midway: assert property (s_midTick |=> !clk_q)
        else $error("sampling clock missed half period fall");
endmodule

// >>> verif/mcs_i2c_host.sv
`timescale 1ns/100ps
// bus host model: four sys clocks per bus phase, data bits move sda only while scl is low, start and stop move it with scl high
module mcs_i2c_host (
    input  wire logic sys_clk,
    input  wire logic sdaOe,
    output logic      sclIn,
    output logic      sdaIn
);
    logic hostScl_q = 1'b1;
    logic hostSda_q = 1'b1;
    // open-drain wire with pull-up, so a released line reads high
    assign sclIn = hostScl_q;
    assign sdaIn = hostSda_q & ~sdaOe;

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one bit; sampled on the last edge before scl falls
    task automatic bit_io(input logic b, output logic r);
        hostSda_q <= b;
        tick(4);
        hostScl_q <= 1'b1;
        tick(4);
        r = sdaIn;
        hostScl_q <= 1'b0;
        tick(2);
    endtask
    task automatic start_cond();
        hostSda_q <= 1'b1;
        tick(4);
        hostScl_q <= 1'b1;
        tick(4);
        hostSda_q <= 1'b0;
        tick(4);
        hostScl_q <= 1'b0;
        tick(2);
    endtask
    task automatic stop_cond();
        hostSda_q <= 1'b0;
        tick(4);
        hostScl_q <= 1'b1;
        tick(4);
        hostSda_q <= 1'b1;
        tick(4);
    endtask
    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask
    // last byte of a read is refused so the device lets go of sda
    task automatic byte_in(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(1'b1, r);
    endtask
    task automatic reg_write(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                             output logic ok);
        logic k0, k1, k2;
        start_cond();
        byte_out({a, 1'b0}, k0);
        byte_out(p, k1);
        byte_out(d, k2);
        stop_cond();
        ok = k0 & k1 & k2;
    endtask
    task automatic reg_read(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                            output logic ok);
        logic k0, k1, k2;
        start_cond();
        byte_out({a, 1'b0}, k0);
        byte_out(p, k1);
        start_cond();
        byte_out({a, 1'b1}, k2);
        byte_in(d);
        stop_cond();
        ok = k0 & k1 & k2;
    endtask
    // hung bus: both lines low, then released on one edge
    task automatic hold_low(input int n);
        hostScl_q <= 1'b0;
        hostSda_q <= 1'b0;
        tick(n);
        hostScl_q <= 1'b1;
        hostSda_q <= 1'b1;
        tick(4);
    endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import mcs_pkg::*;
    localparam int Stuck = 200;
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    mcs_supply_s supplyOk = 4'hf;
    logic        refClockIn = 1'b0;
    logic        intOscTick = 1'b0;
    logic        refRun = 1'b0;
    logic [1:0]  pinHi = 2'h1;
    logic [1:0]  pinLo = 2'h2;
    logic        sclIn, sdaIn, sdaOut, sdaOe, sampClk, extRefActive, alertOut, ok;
    mcs_power_s  powerCtl;
    logic [6:0]  devAddr;
    logic [7:0]  rd;
    int          refCnt = 0;
    int          num_errors = 0;
    int          num_checks = 0;

    always #4 sys_clk = ~sys_clk;
    // 15.6 MHz reference while enabled, oscillator tick every 4 clocks
    always @(posedge sys_clk) begin
        refCnt <= refCnt + 1;
        refClockIn <= refRun & refCnt[2];
        intOscTick <= (refCnt[1:0] == 2'h0);
    end

    mcs_ctrl #(.StuckCycles(Stuck)) mcs_ctrl_i (.sys_clk(sys_clk), .resetn(resetn),
        .supplyOk(supplyOk), .refClockIn(refClockIn), .intOscTick(intOscTick),
        .addrSelectPinHi(pinHi), .addrSelectPinLo(pinLo), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .powerCtl(powerCtl), .sampClk(sampClk),
        .extRefActive(extRefActive), .alertOut(alertOut));
    mcs_i2c_host mcs_i2c_host_i (.sys_clk(sys_clk), .sdaOe(sdaOe), .sclIn(sclIn),
        .sdaIn(sdaIn));

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        mcs_i2c_host_i.reg_write(devAddr, p, d, ok);
        check(16'(ok), 16'h1, "write ack");
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] exp, input string what);
        mcs_i2c_host_i.reg_read(devAddr, p, rd, ok);
        check(16'(ok), 16'h1, "read ack");
        check(16'(rd), 16'(exp), what);
    endtask
    // cycles up to the next sampling clock rise; bounded so a stall ends the run
    task automatic next_rise(output int n);
        logic prev;
        n = 1;
        prev = sampClk;
        @(posedge sys_clk);
        while (!(prev === 1'b0 && sampClk === 1'b1)) begin
            prev = sampClk;
            n++;
            if (n > 4000) begin
                num_errors++;
                $display("[FAIL] %0t sampling clock stalled", $time);
                summarize();
            end
            @(posedge sys_clk);
        end
    endtask

    task automatic t_reset();
        rd_chk(ADDR_CLK_DIV, RST_CLK_DIV, "divider reset");
        rd_chk(ADDR_SYS_CTRL, RST_SYS_CTRL, "sys ctrl reset");
        rd_chk(ADDR_ALERT_EN2, RST_ALERT_EN2, "alert en reset");
        rd_chk(8'h20, READ_ZERO, "unmapped read");
        check(16'(powerCtl), 16'h000e, "power after reset");
        check(16'(extRefActive), 16'h0, "no ext ref");
        check(16'(sdaOut), 16'h0, "open drain data low");
        $display("test reset done");
    endtask
    task automatic t_ext_div();
        int p, pa;
        refRun <= 1'b1;
        repeat (20) @(posedge sys_clk);
        check(16'(extRefActive), 16'h1, "ext ref seen");
        wr(ADDR_CLK_DIV, 8'h10);
        next_rise(p);
        next_rise(pa);
        check(16'(pa), 16'd512, "period of 4x divider ticks");
        // rewrite mid-period: no period may be cut short
        fork
            wr(ADDR_CLK_DIV, 8'h20);
            begin
                next_rise(p);
                for (int i = 0; i < 3; i++) begin
                    next_rise(p);
                    check(16'(p === pa || p === 2 * pa), 16'h1, "whole period");
                end
            end
        join
        next_rise(p);
        check(16'(p), 16'(2 * pa), "period scales with divider");
        $display("test ext divider done");
    endtask
    task automatic t_int_osc();
        int p;
        refRun <= 1'b0;
        repeat (300) @(posedge sys_clk);
        check(16'(extRefActive), 16'h0, "ext ref lost");
        wr(ADDR_CLK_DIV, 8'h02);
        next_rise(p);
        next_rise(p);
        check(16'(p), 16'd64, "internal osc period");
        $display("test internal osc done");
    endtask
    task automatic t_aux();
        wr(ADDR_ADC_CTRL, 8'h80);
        check(16'(powerCtl), 16'h000f, "aux against rail");
        wr(ADDR_ADC_CTRL, 8'h00);
        check(16'(powerCtl), 16'h000e, "aux against ground");
        $display("test aux done");
    endtask
    task automatic t_shutdown();
        wr(ADDR_SYS_CTRL, 8'h40);
        check(16'(powerCtl), 16'h0000, "analog off");
        pinHi <= 2'h2;
        wr(ADDR_ALERT_EN2, 8'h08);
        rd_chk(ADDR_ALERT_EN2, 8'h08, "write in shutdown");
        rd_chk(ADDR_CLK_DIV, 8'h02, "divider kept");
        mcs_i2c_host_i.reg_read({BUS_ADDR_HI, pinHi, pinLo}, ADDR_CLK_DIV, rd, ok);
        check(16'(ok), 16'h0, "pins ignored");
        pinHi <= 2'h1;
        wr(ADDR_SYS_CTRL, 8'h00);
        check(16'(powerCtl), 16'h000e, "analog back");
        rd_chk(ADDR_ALERT_EN2, 8'h08, "kept after wake");
        $display("test shutdown done");
    endtask
    task automatic t_wake();
        wr(ADDR_ALERT_EN2, 8'h00);
        wr(ADDR_SYS_CTRL, 8'h40);
        mcs_i2c_host_i.hold_low(Stuck + 50);
        check(16'(powerCtl), 16'h0000, "no wake when disabled");
        wr(ADDR_SYS_CTRL, 8'h50);
        mcs_i2c_host_i.hold_low(Stuck + 50);
        check(16'(powerCtl), 16'h000e, "woken by hung bus");
        check(16'(alertOut), 16'h0, "alert masked");
        rd_chk(ADDR_SYS_CTRL, 8'h10, "shutdown bit cleared");
        rd_chk(ADDR_FAULT_LATCH_REG_TWO, 8'h02, "wake latched");
        rd_chk(ADDR_STATUS_REG_TWO, 8'h00, "bus no longer stuck");
        wr(ADDR_ALERT_EN2, 8'h08);
        check(16'(alertOut), 16'h1, "alert raised");
        wr(ADDR_FAULT_LATCH_REG_TWO, 8'h00);
        check(16'(alertOut), 16'h0, "alert cleared");
        wr(ADDR_SYS_CTRL, 8'h10 & ~8'h40);
        $display("test wake done");
    endtask
    task automatic t_supply();
        wr(ADDR_CLK_DIV, 8'h06);
        supplyOk <= 4'h7;
        repeat (2) @(posedge sys_clk);
        check(16'(powerCtl.adcEn), 16'h1, "one lockout low");
        supplyOk <= 4'hb;
        repeat (2) @(posedge sys_clk);
        check(16'(powerCtl.adcEn), 16'h1, "either supply enough");
        supplyOk <= 4'h3;
        repeat (2) @(posedge sys_clk);
        check(16'(powerCtl.adcEn), 16'h0, "both lockouts low");
        supplyOk <= 4'hd;
        rd_chk(ADDR_CLK_DIV, 8'h06, "one bus supply kept");
        supplyOk <= 4'hc;
        repeat (4) @(posedge sys_clk);
        supplyOk <= 4'hf;
        repeat (2) @(posedge sys_clk);
        rd_chk(ADDR_CLK_DIV, RST_CLK_DIV, "bus logic reset");
        $display("test supply done");
    endtask

    // main sequence: reset held 20 clocks, then scenarios in turn
    initial begin
        devAddr = {BUS_ADDR_HI, 2'h1, 2'h2};
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_reset();
        t_ext_div();
        t_int_osc();
        t_aux();
        t_shutdown();
        t_wake();
        t_supply();
        summarize();
    end
endmodule
